// [core/fault_params.svh]
`ifndef FAULT_PARAMS_SVH
`define FAULT_PARAMS_SVH
// register byte offsets
`define OFF_PENDING 6'h00
`define OFF_CTRL 6'h04
`define OFF_STATUS 6'h08
`define OFF_IRQ_EN 6'h0c
`define OFF_IRQ_CLR 6'h10
`define OFF_OUT_MASK 6'h14
`define OFF_SEVERITY 6'h18
// ctrl fields
`define CTRL_LOCK_ALLOW 0
`define CTRL_VARIANT_PAT 1
`define CTRL_VARIANT_ERASE 2
`define CTRL_RESET 32'h0000_0000
// interrupt status bits
`define IRQ_RAISED 0
`define IRQ_ACKED 1
`define IRQ_OVERLOAD 2
// fault codes
`define CODE_NONE 8'h00
`define CODE_SELFTEST_MAX 8'h13
`define CODE_WARN_MIN 8'h14
`define CODE_WARN_MAX 8'h63
`define CODE_SERIOUS_MIN 8'h64
`define CODE_SERIOUS_MAX 8'hc7
`define CODE_NV_WRITE 8'h14
`define CODE_ZERO_SAVE 8'h15
`define CODE_CAM_SAVE 8'h16
`define CODE_REC_DELETE 8'h17
`define CODE_PARAM_DELETE 8'h18
`define CODE_COPY_SHIFT 8'h19
`define CODE_DISP_TIMEOUT 8'h1a
`define CODE_PATTERN_SAVE 8'h1b
`define CODE_IDLE_PROG 8'h1c
`define CODE_CAM_ERASE 8'h1d
`define CODE_NO_PERMIT 8'h1e
`define CODE_OVERLOAD 8'h1f
`define CODE_STORE_FULL 8'h20
// blanking after overload acknowledge
`define BLANK_NS 1000
`define CLK_NS 4
`define BLANK_CYC ((`BLANK_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [core/fault_pkg.sv]
`default_nettype none
package fault_pkg;
  typedef enum logic [2:0] {
    SEV_NONE = 3'b001,
    SEV_FATAL = 3'b010,
    SEV_WARN = 3'b100
  } sev_t;
  typedef logic [7:0] code_t;
endpackage
`default_nettype wire

// [core/fault_code_manager.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fault_params.svh"
// Functional notes
// - The highest-priority fault detected in a cycle shows its numeric code on the display output.
// - A code stays pending until the escape key acknowledges it or a newer fault replaces it.
// - Codes 1..19 are self-test faults and are flagged irrecoverable.
// - Warnings 20..99 leave the cam outputs running from the encoder.
// - Storage faults report fixed codes 20, 21, 22 and 23.
// - Parameter deletion outside program 0 raises code 24.
// - A failed program copy or track shift raises code 25.
// - A display access timeout raises code 26.
// - A failed pattern value save raises code 27.
// - Idle time programming failure raises 28, pattern variant only.
// - Cam-erase failure raises 29, erase variant only.
// - Program changes without permit input or lock allowance raise 30.
// - An overcurrent lasting even one cycle raises 31 and switches off that output only.
// - Storage with every record slot taken is refused with code 32.
// - Acknowledging an overload briefly drives all outputs low.
// - Serious codes 100..199 hold all outputs low until the cause clears.
module fault_code_manager #(
  parameter int N_OUT = 32,
  parameter int BLANK_CYCLES = `BLANK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic esc_key_i,
  input wire logic [7:0] selftest_code_i,
  input wire logic nv_write_fail_i,
  input wire logic zero_save_fail_i,
  input wire logic cam_save_fail_i,
  input wire logic rec_delete_fail_i,
  input wire logic param_delete_req_i,
  input wire logic [7:0] program_no_i,
  input wire logic copy_fail_i,
  input wire logic shift_fail_i,
  input wire logic disp_timeout_i,
  input wire logic pattern_save_fail_i,
  input wire logic idle_prog_fail_i,
  input wire logic cam_erase_fail_i,
  input wire logic prog_change_req_i,
  input wire logic prog_permit_i,
  input wire logic [N_OUT-1:0] overcurrent_i,
  input wire logic store_req_i,
  input wire logic store_full_i,
  input wire logic [7:0] serious_code_i,
  input wire logic [N_OUT-1:0] cam_out_i,
  output logic [7:0] display_code_o,
  output logic irrecoverable_o,
  output logic store_refused_o,
  output logic change_refused_o,
  output logic delete_refused_o,
  output logic [N_OUT-1:0] drive_o,
  output logic irq_o
);
  // elaboration-time parameter checks
  if (N_OUT < 1 || N_OUT > 32) begin : g_bad_nout
    $error("N_OUT must be 1..32");
  end
  if (BLANK_CYCLES < 1 || BLANK_CYCLES > 65535) begin : g_bad_blank
    $error("bad BLANK_CYCLES");
  end

  logic [7:0] pending;
  logic [31:0] ctrl;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic [N_OUT-1:0] out_off;
  logic [15:0] blank_cnt;
  logic [7:0] next_code;
  logic raise;
  logic ack_evt;
  logic esc_q;
  logic serious;
  fault_pkg::sev_t sev;
  logic wb_req;
  logic wb_wr;
  logic [N_OUT-1:0] new_over;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && (wb_sel_i == 4'hf);
  assign new_over = overcurrent_i & ~out_off;
  // escape press edge acknowledges
  assign ack_evt = esc_key_i && !esc_q && (pending != `CODE_NONE);
  assign serious = serious_code_i >= `CODE_SERIOUS_MIN &&
    serious_code_i <= `CODE_SERIOUS_MAX;

  // priority encode of fault sources, serious code first, then lowest code wins
  always_comb begin
    next_code = `CODE_NONE;
    if (serious)
      next_code = serious_code_i;
    else if (selftest_code_i != `CODE_NONE &&
             selftest_code_i <= `CODE_SELFTEST_MAX)
      next_code = selftest_code_i;
    else if (nv_write_fail_i)
      next_code = `CODE_NV_WRITE;
    else if (zero_save_fail_i)
      next_code = `CODE_ZERO_SAVE;
    else if (cam_save_fail_i)
      next_code = `CODE_CAM_SAVE;
    else if (rec_delete_fail_i)
      next_code = `CODE_REC_DELETE;
    else if (param_delete_req_i && program_no_i != 8'h00)
      next_code = `CODE_PARAM_DELETE;
    else if (copy_fail_i || shift_fail_i)
      next_code = `CODE_COPY_SHIFT;
    else if (disp_timeout_i)
      next_code = `CODE_DISP_TIMEOUT;
    else if (pattern_save_fail_i)
      next_code = `CODE_PATTERN_SAVE;
    else if (idle_prog_fail_i && ctrl[`CTRL_VARIANT_PAT])
      next_code = `CODE_IDLE_PROG;
    else if (cam_erase_fail_i && ctrl[`CTRL_VARIANT_ERASE])
      next_code = `CODE_CAM_ERASE;
    else if (prog_change_req_i && !prog_permit_i &&
             !ctrl[`CTRL_LOCK_ALLOW])
      next_code = `CODE_NO_PERMIT;
    else if (|new_over)
      next_code = `CODE_OVERLOAD;
    else if (store_req_i && store_full_i)
      next_code = `CODE_STORE_FULL;
  end
  assign raise = next_code != `CODE_NONE;

  always_comb begin
    if (pending == `CODE_NONE)
      sev = fault_pkg::SEV_NONE;
    else if (pending <= `CODE_SELFTEST_MAX)
      sev = fault_pkg::SEV_FATAL;
    else
      sev = fault_pkg::SEV_WARN;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      esc_q <= 1'b0;
    else
      esc_q <= esc_key_i;
  end

  // latch latest, new fault beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i)
      pending <= `CODE_NONE;
    else if (raise)
      pending <= next_code;
    else if (ack_evt)
      pending <= `CODE_NONE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      display_code_o <= `CODE_NONE;
      irrecoverable_o <= 1'b0;
    end else begin
      display_code_o <= pending;
      irrecoverable_o <= (sev == fault_pkg::SEV_FATAL);
    end
  end

  // refusal strobes, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      store_refused_o <= 1'b0;
      change_refused_o <= 1'b0;
      delete_refused_o <= 1'b0;
    end else begin
      store_refused_o <= store_req_i && store_full_i;
      change_refused_o <= prog_change_req_i && !prog_permit_i &&
        !ctrl[`CTRL_LOCK_ALLOW];
      delete_refused_o <= param_delete_req_i && program_no_i != 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      out_off <= '0;
    else if (ack_evt && pending == `CODE_OVERLOAD)
      out_off <= new_over;
    else
      out_off <= out_off | new_over;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      blank_cnt <= 16'h0000;
    else if (ack_evt && pending == `CODE_OVERLOAD)
      blank_cnt <= 16'(BLANK_CYCLES);
    else if (blank_cnt != 16'h0000)
      blank_cnt <= blank_cnt - 16'h0001;
  end

  // warnings keep cams running; serious forces low
  always_ff @(posedge clk_i) begin
    if (rst_i)
      drive_o <= '0;
    else if (serious || blank_cnt != 16'h0000)
      drive_o <= '0;
    else
      drive_o <= cam_out_i & ~out_off & ~new_over;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      ctrl <= `CTRL_RESET;
    else if (wb_wr && wb_adr_i == 6'(`OFF_CTRL))
      ctrl <= wb_dat_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      irq_en <= 3'h0;
    else if (wb_wr && wb_adr_i == 6'(`OFF_IRQ_EN))
      irq_en <= wb_dat_i[2:0];
  end

  // set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i)
      irq_stat <= 3'h0;
    else begin
      if (wb_wr && wb_adr_i == 6'(`OFF_IRQ_CLR))
        irq_stat <= (irq_stat & ~wb_dat_i[2:0]) |
          {|new_over, ack_evt, raise};
      else
        irq_stat <= irq_stat | {|new_over, ack_evt, raise};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat & irq_en);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == 6'(`OFF_PENDING))
          wb_dat_o <= {24'h000000, pending};
        else if (wb_adr_i == 6'(`OFF_CTRL))
          wb_dat_o <= ctrl;
        else if (wb_adr_i == 6'(`OFF_STATUS))
          wb_dat_o <= {29'h0, irq_stat};
        else if (wb_adr_i == 6'(`OFF_IRQ_EN))
          wb_dat_o <= {29'h0, irq_en};
        else if (wb_adr_i == 6'(`OFF_OUT_MASK))
          wb_dat_o <= 32'(out_off);
        else if (wb_adr_i == 6'(`OFF_SEVERITY))
          wb_dat_o <= {29'h0, sev};
      end
    end
  end

  chk_pending_hold:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (pending != 8'h00 && !raise && !ack_evt) |=> pending == $past(pending))
    else $error("pending code changed without cause");
  chk_display_follow:
    assert property (@(posedge clk_i) disable iff (rst_i)
      raise |-> ##2 (display_code_o == $past(next_code, 2)))
    else $error("display did not show code");
  chk_serious_low:
    assert property (@(posedge clk_i) disable iff (rst_i)
      serious |=> drive_o == '0)
    else $error("outputs active during serious fault");
  chk_blank_low:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_evt && pending == 8'h1f) |=> ##1 drive_o == '0)
    else $error("no blanking after overload ack");
  chk_overload_off:
    assert property (@(posedge clk_i) disable iff (rst_i)
      |new_over |=> (drive_o & $past(new_over)) == '0)
    else $error("overloaded output still driven");
  chk_permit_gate:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (prog_change_req_i && prog_permit_i) |=> !change_refused_o)
    else $error("change refused despite permit");
  chk_delete_zero:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (param_delete_req_i && program_no_i == 8'h00) |=> !delete_refused_o)
    else $error("delete refused in program 0");
  chk_fatal_flag:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (pending >= 8'h01 && pending <= 8'h13) |=> irrecoverable_o)
    else $error("self-test code not irrecoverable");
  chk_store_refuse:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (store_req_i && store_full_i) |=> store_refused_o)
    else $error("storage not refused when full");
  chk_warn_run:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (!serious && blank_cnt == 16'h0 && new_over == '0 && out_off == '0)
      |=> drive_o == $past(cam_out_i))
    else $error("outputs not following cams");
endmodule // fault_code_manager
`default_nettype wire

// [sim/esc_panel.sv]
`timescale 1ns/10ps
`default_nettype none
module esc_panel (
  input wire logic clk_i,
  input wire logic press_i,
  output logic esc_key_o
);
  int hold = 0;
  always @(posedge clk_i) begin
    if (press_i) hold <= 6;
    else if (hold > 0) hold <= hold - 1;
  end
  assign esc_key_o = hold > 0;
endmodule // esc_panel
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, press = 0;
  logic esc, permit = 0, irrec, irq, z;
  logic sref, cref, dref, full = 1;
  logic [2:0] refs = 0;
  logic [5:0] adr = 0;
  logic [31:0] wdat = 0, rdat, rd, cam = 0, drv, oc = 0;
  logic [31:0] lfsr = 32'h0ff5f4ba;
  logic [12:0] ev = 0;
  logic [7:0] prg = 0, st = 0, ser = 0, disp, v;
  int err_total = 0, n_tests = 0, cyc_n = 0;
  int codes[$] = '{20, 21, 22, 23, 24, 25, 25, 26, 27, 28, 29, 30, 32};
  always #2 clk_i = ~clk_i;
  esc_panel esc_panel_i (.clk_i(clk_i), .press_i(press), .esc_key_o(esc));
  fault_code_manager #(.N_OUT(32), .BLANK_CYCLES(4)) fault_code_manager_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .esc_key_i(esc), .selftest_code_i(st),
    .nv_write_fail_i(ev[0]), .zero_save_fail_i(ev[1]),
    .cam_save_fail_i(ev[2]), .rec_delete_fail_i(ev[3]),
    .param_delete_req_i(ev[4]), .program_no_i(prg), .copy_fail_i(ev[5]),
    .shift_fail_i(ev[6]), .disp_timeout_i(ev[7]),
    .pattern_save_fail_i(ev[8]), .idle_prog_fail_i(ev[9]),
    .cam_erase_fail_i(ev[10]), .prog_change_req_i(ev[11]),
    .prog_permit_i(permit), .overcurrent_i(oc), .store_req_i(ev[12]),
    .store_full_i(full), .serious_code_i(ser), .cam_out_i(cam),
    .display_code_o(disp), .irrecoverable_o(irrec),
    .store_refused_o(sref), .change_refused_o(cref),
    .delete_refused_o(dref), .drive_o(drv), .irq_o(irq));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // read data is taken at the ack edge only
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0; stb <= 0;
  endtask
  task automatic key();
    @(posedge clk_i) press <= 1;
    @(posedge clk_i) press <= 0;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_i) ev[b] <= 1;
    @(posedge clk_i) ev[b] <= 0;
    // refusal strobes stand one cycle only
    @(posedge clk_i) refs = {sref, cref, dref};
    repeat (2) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    cam <= lfsr | 32'h1;
    chk(disp, 0); // nothing pending
    wb(1, 6'h04, 32'h6);
    wb(1, 6'h0c, 32'h1);
    prg <= 8'h05;
    foreach (codes[i]) begin
      pulse(i);
      chk(disp, codes[i]); // code
      chk(drv, cam); // outputs still follow cam
      chk(refs, {codes[i] == 32, codes[i] == 30, codes[i] == 24});
      repeat (20) @(posedge clk_i);
      chk(disp, codes[i]); // held stable
      wb(0, 6'h00, 0);
      chk(rd, codes[i]); // pending register
      wb(0, 6'h18, 0);
      chk(rd, 32'h4); // warning class
      chk(irq, 1); // interrupt raised
      key();
      chk(disp, 0); // cleared by escape
      wb(0, 6'h08, 0);
      chk(rd, 32'h3); // raised and acknowledged
      wb(1, 6'h10, 32'h7);
      repeat (2) @(posedge clk_i);
      chk(irq, 0); // interrupt cleared
    end
    wb(1, 6'h0c, 32'h0);
    pulse(0);
    chk(irq, 0); // interrupt masked
    key();
    // allowed and variant-disabled cases raise nothing
    prg <= 8'h00;
    permit <= 1;
    wb(1, 6'h04, 32'h0);
    pulse(4);
    chk(disp, 0); // program zero allowed
    chk(refs, 0); // delete not refused
    pulse(11);
    chk(disp, 0); // permit given
    chk(refs, 0); // change not refused
    pulse(9);
    pulse(10);
    chk(disp, 0); // variant absent
    permit <= 0;
    full <= 0;
    wb(1, 6'h04, 32'h1);
    pulse(11);
    chk(refs, 0); // lock allows change
    pulse(12);
    chk(refs, 0); // store has room
    chk(disp, 0); // nothing raised
    wb(0, 6'h1c, 0);
    chk(rd, 0); // unmapped reads zero
    v = 8'(lfsr % 19 + 1);
    lfsr = nxt(lfsr);
    @(posedge clk_i) st <= v;
    @(posedge clk_i) st <= 0;
    repeat (3) @(posedge clk_i);
    chk(disp, v); // self-test code
    chk(irrec, 1); // irrecoverable
    key();
    chk(irrec, 0); // acknowledged
    v = 8'(lfsr % 32);
    lfsr = nxt(lfsr);
    cam <= 32'hffff_ffff;
    @(posedge clk_i) oc <= 32'h1 << v;
    @(posedge clk_i) oc <= 0;
    repeat (3) @(posedge clk_i);
    chk(disp, 31); // overload code
    chk(drv, ~(32'h1 << v)); // only that output off
    wb(0, 6'h14, 0);
    chk(rd, 32'h1 << v); // switched-off mask
    @(posedge clk_i) press <= 1;
    @(posedge clk_i) press <= 0;
    z = 0;
    repeat (8) @(posedge clk_i) if (drv === 0) z = 1;
    chk(z, 1); // brief blanking
    repeat (10) @(posedge clk_i);
    chk(drv, cam); // outputs restored
    v = 8'(lfsr % 100 + 100);
    @(posedge clk_i) ser <= v;
    repeat (4) @(posedge clk_i);
    chk(disp, v); // serious code shown
    repeat (20) @(posedge clk_i);
    chk(drv, 0); // outputs held off
    key();
    chk(drv, 0); // ack does not release
    @(posedge clk_i) ser <= 0;
    repeat (4) @(posedge clk_i);
    chk(drv, cam); // released on removal
    key();
    final_report();
  end
endmodule // tb
`default_nettype wire
